/* File: common/smbp_pkg.sv */
// Purpose: Shared constants for the stacked memory bus port.
// Assumes: Word-addressed 16-bit shared data bus.
// Notes: Density codes select the top address bit of each flash die.
package smbp_pkg;
  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int N_FLASH = 3;
  localparam int N_PSRAM = 2;
  // ----------------------------------------------------------------
  // Top address bit per die density
  // ----------------------------------------------------------------
  localparam int TOP_BIT_256M = 23;
  localparam int TOP_BIT_128M = 22;
  localparam int TOP_BIT_64M = 21;
  localparam int TOP_BIT_32M = 20;
  localparam int TOP_BIT_8M = 18;
  localparam int RSV_LO = 24;
  // Density codes
  localparam logic [2:0] DENS_256M = 3'h0;
  localparam logic [2:0] DENS_128M = 3'h1;
  localparam logic [2:0] DENS_64M = 3'h2;
  localparam logic [2:0] DENS_32M = 3'h3;
  localparam logic [2:0] DENS_8M = 3'h4;
  // Die selected by a RAM access
  typedef enum logic [1:0] {SMBP_RAM_NONE, SMBP_RAM_SRAM, SMBP_RAM_PS1, SMBP_RAM_PS2} smbp_ram_t;
endpackage : smbp_pkg

/* File: src/smbp_port.sv */
// Purpose: Device-side bus port of a stacked flash/SRAM/PSRAM package.
// Assumes: Pins are sampled through two flops on clk (100 MHz, 10 ns).
// Notes: Each die is modelled as select, latch and drive logic only; arrays live outside.
// Behaviour
// - Top decoded word address bit follows density: 23,22,21,20 or 18.
// - Address bit zero selects a 16-bit word; bits 25:24 are ignored.
// - Shared data lines carry host writes in and selected die reads out.
// - Data outputs float when die deselected or its output enable high.
// - Flash die selected only while its low select is low; else standby.
// - Each flash select controls one die; absent dies' selects have no effect.
// - SRAM active while low and high selects asserted; else standby.
// - Each PSRAM die has its own low select; deasserted means standby.
// - Flash enable one gates die one; enable two gates dies two and three.
// - One low RAM output enable drives selected SRAM or PSRAM outputs.
// - Selected flash captures address and data at rising edge of write strobe.
// - RAM write strobe writes only the selected RAM die, apart from flash.
// - Sync reads latch address at valid strobe rise or clock edge while low.
// - Sync reads advance internal address counter on bus clock edges.
// - Async mode latches at strobe rise or flows through while strobe low.
module smbp_port #(
  parameter int FLASH_DIES = 3,        // Flash dies fitted, 1..3
  parameter int PSRAM_DIES = 2,        // PSRAM dies fitted, 0..2
  parameter bit HAS_SRAM = 1'b1,       // SRAM die fitted
  parameter logic [2:0] DENSITY = smbp_pkg::DENS_256M  // Flash die density code
) (
  input wire logic clk,                                   // Bus clock
  input wire logic reset,                                 // Sync reset, high
  input wire logic [smbp_pkg::ADDR_W-1:0] addr,           // Word address pins
  input wire logic [smbp_pkg::DATA_W-1:0] data_in,        // Data pins, input side
  output logic [smbp_pkg::DATA_W-1:0] data_out,           // Data pins, driven value
  output logic data_oe,                                   // Data pins driven
  input wire logic [2:0] flash_sel_n,                     // Flash die selects
  input wire logic sram_select_low,                       // SRAM select, low true
  input wire logic sram_select_high,                      // SRAM select, high true
  input wire logic [1:0] psram_sel_n,                     // PSRAM die selects
  input wire logic [1:0] flash_oe_n,                      // Flash output enables
  input wire logic ram_oe_n,                              // RAM output enable
  input wire logic flash_we_n,                            // Flash write strobe
  input wire logic ram_we_n,                              // RAM write strobe
  input wire logic address_valid_n,                       // Address valid strobe
  input wire logic sync_mode,                             // Flash sync read mode
  input wire logic [smbp_pkg::DATA_W-1:0] flash_rd_data,  // Array word of active flash
  input wire logic [smbp_pkg::DATA_W-1:0] ram_rd_data,    // Array word of active RAM
  output logic [2:0] flash_active,                        // Flash dies out of standby
  output logic sram_active,                               // SRAM out of standby
  output logic [1:0] psram_active,                        // PSRAM dies out of standby
  output logic [smbp_pkg::ADDR_W-1:0] flash_addr_ff,      // Flash read address
  output logic [2:0] flash_wr_pulse,                      // Flash write, per die
  output logic [smbp_pkg::ADDR_W-1:0] flash_wr_addr_ff,   // Captured write address
  output logic [smbp_pkg::DATA_W-1:0] flash_wr_data_ff,   // Captured write data
  output logic [2:0] ram_wr_en,                           // RAM write: sram, ps1, ps2
  output logic [smbp_pkg::ADDR_W-1:0] ram_addr,           // RAM word address
  output logic [smbp_pkg::DATA_W-1:0] ram_wr_data         // RAM write data
);
  initial begin
    if (FLASH_DIES < 1 || FLASH_DIES > smbp_pkg::N_FLASH) $error("FLASH_DIES out of range");
    if (PSRAM_DIES < 0 || PSRAM_DIES > smbp_pkg::N_PSRAM) $error("PSRAM_DIES out of range");
    if (DENSITY > smbp_pkg::DENS_8M) $error("DENSITY code unknown");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = smbp_pkg::ADDR_W + smbp_pkg::DATA_W + 14;
  logic [PIN_W-1:0] meta_ff;
  logic [PIN_W-1:0] pin_ff;
  // Two flops on every pin; only pin_ff is read
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= '1;
      pin_ff <= '1;
    end else begin
      meta_ff <= {addr, data_in, flash_sel_n, sram_select_low, sram_select_high, psram_sel_n,
                  flash_oe_n, ram_oe_n, flash_we_n, ram_we_n, address_valid_n, sync_mode};
      pin_ff <= meta_ff;
    end
  end
  logic [smbp_pkg::ADDR_W-1:0] s_addr;
  logic [smbp_pkg::DATA_W-1:0] s_data;
  logic [2:0] s_fce_n;
  logic s_scs_n, s_scs, s_roe_n, s_fwe_n, s_rwe_n, s_adv_n, s_sync;
  logic [1:0] s_pcs_n, s_foe_n;
  assign {s_addr, s_data, s_fce_n, s_scs_n, s_scs, s_pcs_n, s_foe_n, s_roe_n, s_fwe_n,
          s_rwe_n, s_adv_n, s_sync} = pin_ff;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  int top_bit;
  logic [smbp_pkg::ADDR_W-1:0] addr_mask;
  // Mask above the density's top bit, reserved bits never decoded
  always_comb begin
    case (DENSITY)
      smbp_pkg::DENS_256M: top_bit = smbp_pkg::TOP_BIT_256M;
      smbp_pkg::DENS_128M: top_bit = smbp_pkg::TOP_BIT_128M;
      smbp_pkg::DENS_64M: top_bit = smbp_pkg::TOP_BIT_64M;
      smbp_pkg::DENS_32M: top_bit = smbp_pkg::TOP_BIT_32M;
      default: top_bit = smbp_pkg::TOP_BIT_8M;
    endcase
    for (int i = 0; i < smbp_pkg::ADDR_W; i++) begin
      addr_mask[i] = (i <= top_bit) && (i < smbp_pkg::RSV_LO);
    end
  end
  logic [smbp_pkg::ADDR_W-1:0] word_addr;
  assign word_addr = s_addr & addr_mask;  // Bit 0 is a word, not a byte

  // ----------------------------------------------------------------
  // Die selects
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < smbp_pkg::N_FLASH; g++) begin : g_fsel
      // Absent dies ignore their select pin
      assign flash_active[g] = (g < FLASH_DIES) && !s_fce_n[g];
    end
    for (g = 0; g < smbp_pkg::N_PSRAM; g++) begin : g_psel
      assign psram_active[g] = (g < PSRAM_DIES) && !s_pcs_n[g];
    end
  endgenerate
  assign sram_active = HAS_SRAM && !s_scs_n && s_scs;

  // Output enable per flash die: die one on enable one, others on enable two
  logic [2:0] flash_drive;
  assign flash_drive = flash_active & {!s_foe_n[1], !s_foe_n[1], !s_foe_n[0]};
  logic ram_drive;
  assign ram_drive = (sram_active || (|psram_active)) && !s_roe_n;

  // ----------------------------------------------------------------
  // Flash address latch and burst counter
  // ----------------------------------------------------------------
  logic adv_prev_ff;
  logic sync_latched_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      adv_prev_ff <= 1'b1;
    end else begin
      adv_prev_ff <= s_adv_n;
    end
  end
  logic adv_rise;
  assign adv_rise = s_adv_n && !adv_prev_ff;
  // Latch, flow through or count the flash read address
  always_ff @(posedge clk) begin
    if (reset) begin
      flash_addr_ff <= '0;
      sync_latched_ff <= 1'b0;
    end else if (|flash_active) begin
      if (s_sync) begin
        // A new low period of the strobe rearms the latch; the burst runs until then
        if (!s_adv_n && (!sync_latched_ff || adv_prev_ff)) begin
          flash_addr_ff <= word_addr;  // First clock edge with strobe low
          sync_latched_ff <= 1'b1;
        end else if (adv_rise && !sync_latched_ff) begin
          flash_addr_ff <= word_addr;  // Strobe rise came first
          sync_latched_ff <= 1'b1;
        end else if (s_adv_n && sync_latched_ff) begin
          flash_addr_ff <= (flash_addr_ff + 1'b1) & addr_mask;
        end
      end else if (!s_adv_n || adv_rise) begin
        flash_addr_ff <= word_addr;  // Flow through, hold at rise
        sync_latched_ff <= 1'b0;
      end
    end else begin
      sync_latched_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flash write capture
  // ----------------------------------------------------------------
  logic fwe_prev_ff;
  logic [2:0] fsel_at_we_ff;
  // Track strobe and the dies selected one cycle earlier
  always_ff @(posedge clk) begin
    if (reset) begin
      fwe_prev_ff <= 1'b1;
      fsel_at_we_ff <= '0;
    end else begin
      fwe_prev_ff <= s_fwe_n;
      fsel_at_we_ff <= flash_active;
    end
  end
  logic fwe_rise;
  assign fwe_rise = s_fwe_n && !fwe_prev_ff;
  // Address and data captured on strobe rise
  always_ff @(posedge clk) begin
    if (reset) begin
      flash_wr_pulse <= '0;
      flash_wr_addr_ff <= '0;
      flash_wr_data_ff <= '0;
    end else begin
      flash_wr_pulse <= fwe_rise ? fsel_at_we_ff : 3'h0;
      if (fwe_rise && |fsel_at_we_ff) begin
        flash_wr_addr_ff <= word_addr;
        flash_wr_data_ff <= s_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // RAM write path
  // ----------------------------------------------------------------
  // Only the RAM strobe writes RAM dies
  assign ram_wr_en = {psram_active[1], psram_active[0], sram_active} & {3{!s_rwe_n}};
  assign ram_addr = s_addr & {{(smbp_pkg::ADDR_W - smbp_pkg::RSV_LO){1'b0}},
                              {smbp_pkg::RSV_LO{1'b1}}};
  assign ram_wr_data = s_data;

  // ----------------------------------------------------------------
  // Shared data output
  // ----------------------------------------------------------------
  // Flash has priority if the host breaks the one-driver contract
  always_ff @(posedge clk) begin
    if (reset) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      data_oe <= (|flash_drive) || ram_drive;
      data_out <= (|flash_drive) ? flash_rd_data : (ram_drive ? ram_rd_data : 16'h0000);
    end
  end
endmodule : smbp_port

/* File: dv/smbp_port_properties.sv */
// Purpose: Pin-level assertions for the stacked memory bus port.
// Assumes: Pins are seen two edges late and outputs are driven one edge after that.
// Notes: Attached to smbp_port by bind at the foot of this file.
module smbp_port_properties (
  input wire logic clk, // Bus clock
  input wire logic reset, // Sync reset
  input wire logic [smbp_pkg::DATA_W-1:0] data_out, // Driven word
  input wire logic data_oe, // Data pins driven
  input wire logic [2:0] flash_sel_n, // Flash selects
  input wire logic sram_select_low, // SRAM select low
  input wire logic sram_select_high, // SRAM select high
  input wire logic [1:0] psram_sel_n, // PSRAM selects
  input wire logic [1:0] flash_oe_n, // Flash enables
  input wire logic ram_oe_n, // RAM enable
  input wire logic flash_we_n, // Flash strobe
  input wire logic ram_we_n, // RAM strobe
  input wire logic [smbp_pkg::DATA_W-1:0] flash_rd_data, // Flash word
  input wire logic [smbp_pkg::DATA_W-1:0] ram_rd_data, // RAM word
  input wire logic [2:0] flash_active, // Flash actives
  input wire logic sram_active, // SRAM active
  input wire logic [1:0] psram_active, // PSRAM actives
  input wire logic [2:0] flash_wr_pulse, // Write pulses
  input wire logic [2:0] ram_wr_en // RAM writes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fl_drv;
  logic ram_drv;
  logic sram_on;
  // Which die the pins ask to drive the data lines
  assign sram_on = !sram_select_low && sram_select_high;
  assign fl_drv = (!flash_sel_n[0] && !flash_oe_n[0]) || (!(&flash_sel_n[2:1]) && !flash_oe_n[1]);
  assign ram_drv = !ram_oe_n && (sram_on || !(&psram_sel_n));
  logic [2:0] warm_ff = 3'h0;
  // Hold the checks off until the deepest look-back has real history
  always_ff @(posedge clk) begin
    if (warm_ff != 3'h7) begin
      warm_ff <= warm_ff + 3'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset || warm_ff < 3'h5);
  // Strobe rise with the selects held steady around it
  sequence s_we_rise;
    !flash_we_n ##1 (flash_we_n && $stable(flash_sel_n)) ##1 $stable(flash_sel_n);
  endsequence
  property p_flash_sel; flash_active == ~$past(flash_sel_n, 2); endproperty
  a_flash_sel: assert property (p_flash_sel) else $error("flash active wrong");
  property p_sram; sram_active == $past(sram_on, 2); endproperty
  a_sram: assert property (p_sram) else $error("sram active wrong");
  property p_psram; psram_active == ~$past(psram_sel_n, 2); endproperty
  a_psram: assert property (p_psram) else $error("psram active wrong");
  property p_oe; data_oe == $past(fl_drv || ram_drv, 3); endproperty
  a_oe: assert property (p_oe) else $error("data enable wrong");
  property p_dout_fl; data_oe && $past(fl_drv, 3) |-> data_out == $past(flash_rd_data); endproperty
  a_dout_fl: assert property (p_dout_fl) else $error("flash word wrong");
  property p_dout_ram; data_oe && $past(ram_drv && !fl_drv, 3) |-> data_out == $past(ram_rd_data);
  endproperty
  a_dout_ram: assert property (p_dout_ram) else $error("ram word wrong");
  property p_wr_pulse; s_we_rise |-> ##2 flash_wr_pulse == ~$past(flash_sel_n, 3); endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("flash write pulse wrong");
  property p_ram_wr;
    ram_wr_en == $past({!psram_sel_n[1], !psram_sel_n[0], sram_on} & {3{!ram_we_n}}, 2);
  endproperty
  a_ram_wr: assert property (p_ram_wr) else $error("ram write enable wrong");
endmodule : smbp_port_properties
bind smbp_port smbp_port_properties smbp_port_properties_inst (.clk, .reset, .data_out, .data_oe,
  .flash_sel_n, .sram_select_low, .sram_select_high, .psram_sel_n, .flash_oe_n, .ram_oe_n,
  .flash_we_n, .ram_we_n, .flash_rd_data, .ram_rd_data, .flash_active, .sram_active,
  .psram_active, .flash_wr_pulse, .ram_wr_en);

/* File: dv/smbp_array_model.sv */
// Purpose: Array words returned by the dies behind the port.
// Assumes: Words depend only on which die is active and on the RAM address.
// Notes: Patterns make the source die visible in the driven word.
module smbp_array_model (
  input wire logic [2:0] flash_active, // Flash actives
  input wire logic sram_active, // SRAM active
  input wire logic [1:0] psram_active, // PSRAM actives
  input wire logic [smbp_pkg::ADDR_W-1:0] ram_addr, // RAM address
  output logic [smbp_pkg::DATA_W-1:0] flash_rd_data, // Flash word
  output logic [smbp_pkg::DATA_W-1:0] ram_rd_data // RAM word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Die identity sits in the word so a wrong source shows
  assign flash_rd_data = {13'h0f1a, flash_active};
  assign ram_rd_data = {sram_active, psram_active, ram_addr[12:0]};
endmodule : smbp_array_model

/* File: dv/test_stacked_memory_bus_port.sv */
// Purpose: Self-checking bench for the stacked memory bus port.
// Assumes: Pins driven at the falling edge; density 256M, all dies fitted.
// Notes: Select and enable combinations run from a table.
module test_stacked_memory_bus_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, data_oe, sram_select_low, sram_select_high, ram_oe_n, flash_we_n, ram_we_n;
  logic address_valid_n, sync_mode, sram_active;
  logic [25:0] addr, flash_addr_ff, flash_wr_addr_ff, ram_addr, a_seen;
  logic [15:0] data_in, data_out, flash_rd_data, ram_rd_data, flash_wr_data_ff, ram_wr_data;
  logic [2:0] flash_sel_n, flash_active, flash_wr_pulse, ram_wr_en;
  logic [1:0] psram_sel_n, flash_oe_n, psram_active;
  int fail_count = 0;
  int num_checks = 0;
  // Pins {fsel, slo, shi, psel, foe, roe}, expected enable, expected word
  logic [26:0] rows [10] = '{{10'h35d, 1'h1, 16'h78d1}, {10'h2db, 1'h1, 16'h78d2},
    {10'h1db, 1'h1, 16'h78d4}, {10'h2df, 1'h0, 16'h0}, {10'h3be, 1'h1, 16'h8000},
    {10'h3de, 1'h0, 16'h0}, {10'h3d6, 1'h1, 16'h2000}, {10'h3ce, 1'h1, 16'h4000},
    {10'h3d7, 1'h0, 16'h0}, {10'h3db, 1'h0, 16'h0}};
  smbp_port smbp_port_inst (.clk, .reset, .addr, .data_in, .data_out, .data_oe, .flash_sel_n,
    .sram_select_low, .sram_select_high, .psram_sel_n, .flash_oe_n, .ram_oe_n, .flash_we_n,
    .ram_we_n, .address_valid_n, .sync_mode, .flash_rd_data, .ram_rd_data, .flash_active,
    .sram_active, .psram_active, .flash_addr_ff, .flash_wr_pulse, .flash_wr_addr_ff,
    .flash_wr_data_ff, .ram_wr_en, .ram_addr, .ram_wr_data);
  smbp_array_model smbp_array_model_inst (.flash_active, .sram_active, .psram_active, .ram_addr,
    .flash_rd_data, .ram_rd_data);
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Deselect every die, release strobes, then let n cycles pass
  task automatic idle(input int n);
    {flash_sel_n, sram_select_low, sram_select_high, psram_sel_n, flash_oe_n, ram_oe_n} = 10'h3df;
    flash_we_n = 1'b1;
    ram_we_n = 1'b1;
    address_valid_n = 1'b1;
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    reset = 1'b1;
    addr = 26'h0;
    data_in = 16'h0;
    sync_mode = 1'b0;
    idle(2);
    reset = 1'b0;
    idle(4);
    check(26'(data_oe), 26'h0);
    check(26'(flash_active), 26'h0);
    foreach (rows[i]) begin
      {flash_sel_n, sram_select_low, sram_select_high, psram_sel_n, flash_oe_n,
       ram_oe_n} = rows[i][26:17];
      repeat (4) @(negedge clk);
      check(26'(data_oe), 26'(rows[i][16]));
      if (rows[i][16]) check(26'(data_out), 26'(rows[i][15:0]));
      idle(4);
    end
    // Async flow-through, masking of the reserved bits, hold after strobe rise
    flash_sel_n = 3'h6;
    address_valid_n = 1'b0;
    addr = 26'h3abcdef;
    repeat (5) @(negedge clk);
    check(flash_addr_ff, 26'h0abcdef);
    check(ram_addr, 26'h0abcdef);
    address_valid_n = 1'b1;
    repeat (3) @(negedge clk);
    addr = 26'h0001234;
    repeat (5) @(negedge clk);
    check(flash_addr_ff, 26'h0abcdef);
    // Sync latch then burst advance with the strobe high
    sync_mode = 1'b1;
    address_valid_n = 1'b0;
    addr = 26'h0000100;
    repeat (5) @(negedge clk);
    check(flash_addr_ff, 26'h0000100);
    address_valid_n = 1'b1;
    repeat (4) @(negedge clk);
    a_seen = flash_addr_ff;
    @(negedge clk);
    check(flash_addr_ff, a_seen + 26'h1);
    sync_mode = 1'b0;
    idle(4);
    // Flash write to die two, address and data held across the strobe rise
    flash_sel_n = 3'h5;
    addr = 26'h0012345;
    data_in = 16'hbeef;
    flash_we_n = 1'b0;
    repeat (3) @(negedge clk);
    flash_we_n = 1'b1;
    for (int k = 0; k < 8 && flash_wr_pulse === 3'h0; k++) @(negedge clk);
    check(26'(flash_wr_pulse), 26'h2);
    check(flash_wr_addr_ff, 26'h0012345);
    check(26'(flash_wr_data_ff), 26'hbeef);
    idle(4);
    // RAM write reaches only the SRAM, flash strobe path stays quiet
    sram_select_low = 1'b0;
    sram_select_high = 1'b1;
    data_in = 16'h1234;
    ram_we_n = 1'b0;
    repeat (4) @(negedge clk);
    check(26'(ram_wr_en), 26'h1);
    check(26'(ram_wr_data), 26'h1234);
    check(26'(flash_wr_pulse), 26'h0);
    idle(4);
    // Reset in mid-run while die one drives, then the same read again
    {flash_sel_n, sram_select_low, sram_select_high, psram_sel_n, flash_oe_n,
     ram_oe_n} = 10'h35d;
    repeat (4) @(negedge clk);
    check(26'(data_oe), 26'h1);
    reset = 1'b1;
    idle(3);
    check(26'(data_oe), 26'h0);
    check(flash_wr_addr_ff, 26'h0);
    reset = 1'b0;
    idle(4);
    check(26'(data_oe), 26'h0);
    {flash_sel_n, sram_select_low, sram_select_high, psram_sel_n, flash_oe_n,
     ram_oe_n} = 10'h35d;
    repeat (4) @(negedge clk);
    check(26'(data_out), 26'h78d1);
    idle(4);
    end_of_test();
  end
endmodule : test_stacked_memory_bus_port
